// ===== rtl/sfp_core.sv
// serial command front end, write fifo, buffers and self-timed sequencer
`timescale 1ns/100ps
`default_nettype none

//------------------------------------------------------------------------------
// fifo between the serial front end and the buffer memories
//------------------------------------------------------------------------------
module sfp_fifo #(
    parameter int W = 18,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp, rp, next_wp, next_rp;

    // pointers carry one extra bit so full and empty differ
    always_comb
    begin
        next_wp = wp;
        next_rp = rp;
        if (in_valid && in_ready)
            next_wp = wp + 1'b1;
        if (out_valid && out_ready)
            next_rp = rp + 1'b1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wp <= '0;
            rp <= '0;
        end
        else
        begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    // storage has no reset, only valid entries are ever read
    always_ff @(posedge clk)
    begin
        if (in_valid && in_ready)
            mem[wp[AW-1:0]] <= in_data;
    end

    assign in_ready = (wp - rp) != (AW+1)'(D);
    assign out_valid = wp != rp;
    assign out_data = mem[rp[AW-1:0]];
endmodule : sfp_fifo

//------------------------------------------------------------------------------
// top: command decode and sequencing
//------------------------------------------------------------------------------
module sfp_core #(
    parameter int XFR_US = 300,
    parameter int PAGE_ER_US = 8000,
    parameter int BLK_ER_US = 12000,
    parameter int PROG_US = 14000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic [7:0] status,
    output logic buf_ready,
    output sfp_pkg::sfp_arr_s arr,
    input wire logic arr_mismatch,
    input wire logic rd_sel,
    input wire logic [sfp_pkg::BUF_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    import sfp_pkg::*;

    localparam logic [31:0] XFR_CYC = 32'(XFR_US * CLK_MHZ);
    localparam logic [31:0] PAGE_ER_CYC = 32'(PAGE_ER_US * CLK_MHZ);
    localparam logic [31:0] BLK_ER_CYC = 32'(BLK_ER_US * CLK_MHZ);
    localparam logic [31:0] PROG_CYC = 32'(PROG_US * CLK_MHZ);

    //--------------------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------------------
    logic [2:0] pin_m, pin_s;
    logic sck_d, cs_d;
    logic cs_s, sck_s, si_s, sck_rise, cs_rise;

    // the serial clock is sampled, so it must stay well below clk / 4
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_m <= 3'h7;
            pin_s <= 3'h7;
            sck_d <= 1'b1;
            cs_d <= 1'b1;
        end
        else
        begin
            pin_m <= {cs_n, sck, si};
            pin_s <= pin_m;
            sck_d <= pin_s[1];
            cs_d <= pin_s[2];
        end
    end

    assign {cs_s, sck_s, si_s} = pin_s;
    assign sck_rise = sck_s & ~sck_d & ~cs_s;
    assign cs_rise = cs_s & ~cs_d;

    //--------------------------------------------------------------------------
    // serial front end
    //--------------------------------------------------------------------------
    logic [5:0] hdr_cnt, next_hdr_cnt;
    logic [31:0] hdr, next_hdr;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] dat, next_dat;
    logic [BUF_AW-1:0] wr_addr, next_wr_addr;
    logic hdr_full, push;
    sfp_job_s job_now;
    sfp_wr_s fifo_in, fifo_out;
    logic fifo_out_valid, fifo_out_ready;

    assign hdr_full = hdr_cnt == 6'(HDR_BITS);
    assign job_now = sfp_decode(hdr[31:24], hdr[23:0]);
    assign push = sck_rise && hdr_full && (bit_cnt == 3'h7) && job_now.wr;
    assign fifo_in = '{addr: wr_addr, sel: job_now.sel, data: {dat[6:0], si_s}};

    // header shifts msb first; data bytes follow once the header is full
    always_comb
    begin
        next_hdr_cnt = hdr_cnt;
        next_hdr = hdr;
        next_bit_cnt = bit_cnt;
        next_dat = dat;
        next_wr_addr = wr_addr;
        if (cs_s)
        begin
            next_hdr_cnt = '0;
            next_bit_cnt = '0;
        end
        else if (sck_rise && !hdr_full)
        begin
            next_hdr_cnt = hdr_cnt + 1'b1;
            next_hdr = {hdr[30:0], si_s};
            if (hdr_cnt == 6'(HDR_BITS - 1))
                next_wr_addr = next_hdr[BUF_AW-1:0];
        end
        else if (sck_rise)
        begin
            next_bit_cnt = bit_cnt + 1'b1;
            next_dat = {dat[6:0], si_s};
        end
        if (push)
            next_wr_addr = (wr_addr >= BUF_LAST) ? '0 : wr_addr + 1'b1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hdr_cnt <= '0;
            hdr <= '0;
            bit_cnt <= '0;
            dat <= '0;
            wr_addr <= '0;
        end
        else
        begin
            hdr_cnt <= next_hdr_cnt;
            hdr <= next_hdr;
            bit_cnt <= next_bit_cnt;
            dat <= next_dat;
            wr_addr <= next_wr_addr;
        end
    end

    // a byte offered while the fifo is full is lost; buf_ready warns the host
    sfp_fifo #(.W($bits(sfp_wr_s)), .D(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(fifo_in),
        .in_valid(push),
        .in_ready(buf_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    //--------------------------------------------------------------------------
    // buffer memories
    //--------------------------------------------------------------------------
    logic [7:0] buf_mem [2][BUF_BYTES];

    // writes stall while a transfer owns the same buffer
    assign fifo_out_ready = !(arr.phase == PH_XFER && arr.sel == fifo_out.sel);

    always_ff @(posedge clk)
    begin
        if (fifo_out_valid && fifo_out_ready)
            buf_mem[fifo_out.sel][fifo_out.addr] <= fifo_out.data;
        rd_data <= buf_mem[rd_sel][rd_addr];
    end

    //--------------------------------------------------------------------------
    // self-timed sequencer
    //--------------------------------------------------------------------------
    sfp_job_s job, next_job;
    logic [31:0] tmr, next_tmr;
    logic comp, next_comp, launch, tmr_done;
    sfp_phase_e phase, next_phase;

    // busy array ignores new array commands, the host is to wait
    assign launch = cs_rise && hdr_full && job_now.valid && arr.phase == PH_IDLE;
    assign tmr_done = tmr == '0;

    function automatic logic [31:0] phase_cycles(input sfp_phase_e p, input logic blk);
        logic [31:0] c;
        c = PROG_CYC;
        if (p == PH_XFER)
            c = XFR_CYC;
        else if (p == PH_ERASE)
            c = blk ? BLK_ER_CYC : PAGE_ER_CYC;
        return c - 1'b1;
    endfunction : phase_cycles

    // phases run transfer, erase, program, skipping those the job lacks
    always_comb
    begin
        next_phase = arr.phase;
        next_job = job;
        next_tmr = tmr;
        next_comp = comp;
        unique case (arr.phase)
            PH_IDLE:
                if (launch)
                begin
                    next_job = job_now;
                    next_phase = PH_DRAIN;
                end
            PH_DRAIN:
                // program-through data must reach the buffer first
                if (!fifo_out_valid)
                begin
                    next_phase = job.xfer ? PH_XFER : (job.erase ? PH_ERASE : PH_PROG);
                    next_tmr = phase_cycles(next_phase, job.block);
                end
            PH_XFER:
                if (tmr_done)
                begin
                    if (job.cmp)
                        next_comp = arr_mismatch;
                    next_phase = job.erase ? PH_ERASE : PH_IDLE;
                    next_tmr = phase_cycles(next_phase, job.block);
                end
                else
                    next_tmr = tmr - 1'b1;
            PH_ERASE:
                if (tmr_done)
                begin
                    next_phase = job.prog ? PH_PROG : PH_IDLE;
                    next_tmr = phase_cycles(next_phase, job.block);
                end
                else
                    next_tmr = tmr - 1'b1;
            PH_PROG:
                if (tmr_done)
                    next_phase = PH_IDLE;
                else
                    next_tmr = tmr - 1'b1;
            default:
                next_phase = PH_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase <= PH_IDLE;
            job <= '0;
            tmr <= '0;
            comp <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            job <= next_job;
            tmr <= next_tmr;
            comp <= next_comp;
        end
    end

    // one driver for the whole struct keeps the output a single variable
    assign arr = '{phase: phase, block: job.block, sel: job.sel, page: job.page};

    // status byte: ready, compare result, density code
    always_comb
    begin
        status = '0;
        status[RDY_BIT] = arr.phase == PH_IDLE;
        status[CMP_BIT] = comp;
        status[DENS_LSB +: 4] = DENSITY;
    end

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_launch_busy: assert property (launch |=> !status[RDY_BIT] && job.valid)
        else $error("launch did not raise busy");
    chk_short_discard: assert property (cs_rise && !hdr_full && arr.phase == PH_IDLE
        |=> arr.phase == PH_IDLE)
        else $error("short command was launched");
    chk_busy_cause: assert property ($fell(status[RDY_BIT]) |-> $past(launch))
        else $error("busy without launch");
    chk_cmp_update: assert property ($changed(comp)
        |-> $past(arr.phase == PH_XFER && tmr_done && job.cmp))
        else $error("compare bit changed outside compare end");
    chk_erase_then_prog: assert property (arr.phase == PH_ERASE && tmr_done && job.prog
        |=> arr.phase == PH_PROG && tmr == PROG_CYC - 1)
        else $error("program did not follow erase");
    chk_rewrite_order: assert property (arr.phase == PH_XFER && tmr_done && job.erase
        |=> arr.phase == PH_ERASE)
        else $error("rewrite skipped erase");
    chk_buf_wrap: assert property (push && wr_addr == BUF_LAST |=> wr_addr == '0)
        else $error("buffer address did not wrap");
    chk_block_page: assert property (arr.block |-> arr.page[BLK_LSB-1:0] == '0)
        else $error("block erase page low bits not cleared");
    chk_noerase_prog: assert property (arr.phase == PH_DRAIN && !fifo_out_valid
        && !job.xfer && !job.erase |=> arr.phase == PH_PROG)
        else $error("program without erase took wrong phase");

    cov_compare_mismatch: cover property (arr.phase == PH_XFER && tmr_done && job.cmp
        && arr_mismatch);
    cov_rewrite: cover property (arr.phase == PH_ERASE && job.xfer && job.prog);
    cov_fifo_full: cover property (push && !buf_ready);
    cov_block_erase: cover property (launch && job_now.block);
endmodule : sfp_core

`default_nettype wire

// ===== rtl/sfp_pkg.sv
// constants, types and opcode decoding for the serial flash program/erase sequencer
//------------------------------------------------------------------------------
// Notes on behaviour
// - buffer write 84H/87H, 15 ignored, 9-bit address
// - data bytes fill buffer, wrap, until select rises
// - program-with-erase 83H/86H, reserved, page, ignored bits
// - erase page then program it, busy throughout
// - program without erase 88H/89H, busy meanwhile
// - page erase 81H erases addressed page, busy
// - block erase 50H erases eight pages, busy
// - block number is page bits 11 to 3
// - program-through-buffer 82H/85H, page, start, data
// - program-through-buffer erases then programs, busy throughout
// - page-to-buffer transfer 53H/55H, busy until done
// - compare 60H/61H checks whole page, busy
// - compare result lands in status bit 6
// - rewrite 58H/59H: transfer, erase, program, busy
// - bit 6 zero on match, one on mismatch
// - bit 7 one when idle, zero when busy
// - input sampled on rising serial clock
//------------------------------------------------------------------------------
package sfp_pkg;
    localparam logic [7:0] OP_BUF_WR1 = 8'h84, OP_BUF_WR2 = 8'h87;
    localparam logic [7:0] OP_PGM_ER1 = 8'h83, OP_PGM_ER2 = 8'h86;
    localparam logic [7:0] OP_PGM_NE1 = 8'h88, OP_PGM_NE2 = 8'h89;
    localparam logic [7:0] OP_PAGE_ER = 8'h81, OP_BLK_ER = 8'h50;
    localparam logic [7:0] OP_THRU1 = 8'h82, OP_THRU2 = 8'h85;
    localparam logic [7:0] OP_XFR1 = 8'h53, OP_XFR2 = 8'h55;
    localparam logic [7:0] OP_CMP1 = 8'h60, OP_CMP2 = 8'h61;
    localparam logic [7:0] OP_RW1 = 8'h58, OP_RW2 = 8'h59;
    localparam int HDR_BITS = 32;       // opcode plus 24 address bits
    localparam int BUF_AW = 9;
    localparam logic [8:0] BUF_LAST = 9'h107;   // 264 bytes per buffer
    localparam int BUF_BYTES = 264;
    localparam int PAGE_W = 12;
    localparam int PAGE_LSB = 9;
    localparam int BLK_LSB = 3;
    localparam int RDY_BIT = 7;
    localparam int CMP_BIT = 6;
    localparam int DENS_LSB = 2;
    localparam logic [3:0] DENSITY = 4'h9;
    localparam int CLK_MHZ = 50;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [2:0] {PH_IDLE, PH_DRAIN, PH_XFER, PH_ERASE, PH_PROG} sfp_phase_e;

    typedef struct packed {
        logic valid;                // launches an array operation
        logic wr;                   // carries data bytes for a buffer
        logic xfer;
        logic erase;
        logic prog;
        logic block;
        logic cmp;
        logic sel;                  // 0 first buffer, 1 second buffer
        logic [PAGE_W-1:0] page;
    } sfp_job_s;

    typedef struct packed {
        logic [BUF_AW-1:0] addr;
        logic sel;
        logic [7:0] data;
    } sfp_wr_s;

    typedef struct packed {
        sfp_phase_e phase;
        logic block;
        logic sel;
        logic [PAGE_W-1:0] page;
    } sfp_arr_s;

    // opcode and address word into a job; unknown opcodes give a job with every flag clear
    function automatic sfp_job_s sfp_decode(input logic [7:0] op, input logic [23:0] a);
        sfp_job_s j;
        j = '0;
        j.page = a[PAGE_LSB +: PAGE_W];
        j.sel = op inside {OP_BUF_WR2, OP_PGM_ER2, OP_PGM_NE2, OP_THRU2,
                           OP_XFR2, OP_CMP2, OP_RW2};
        case (op)
            OP_BUF_WR1, OP_BUF_WR2: j.wr = 1'b1;
            OP_PGM_ER1, OP_PGM_ER2: {j.valid, j.erase, j.prog} = 3'h7;
            OP_PGM_NE1, OP_PGM_NE2: {j.valid, j.prog} = 2'h3;
            OP_PAGE_ER: {j.valid, j.erase} = 2'h3;
            OP_BLK_ER: {j.valid, j.erase, j.block} = 3'h7;
            OP_THRU1, OP_THRU2: {j.valid, j.wr, j.erase, j.prog} = 4'hF;
            OP_XFR1, OP_XFR2: {j.valid, j.xfer} = 2'h3;
            OP_CMP1, OP_CMP2: {j.valid, j.xfer, j.cmp} = 3'h7;
            OP_RW1, OP_RW2: {j.valid, j.xfer, j.erase, j.prog} = 4'hF;
            default: j.valid = 1'b0;
        endcase
        if (j.block)
            j.page[BLK_LSB-1:0] = '0;
        return j;
    endfunction : sfp_decode
endpackage : sfp_pkg

// ===== tb/sfp_host.sv
// serial host model that drives the sequencer's select, clock and data pins
`timescale 1ns/100ps
`default_nettype none

module sfp_host
(
    input wire logic clk,
    output logic cs_n,
    output logic sck,
    output logic si
);
    // idle pins: select high, serial clock parked high between frames
    initial
    begin
        cs_n <= 1'b1;
        sck <= 1'b1;
        si <= 1'b0;
    end

    // one bit, four clocks low then four high: data moves with the fall
    // so it has long settled when the sampled rise is found
    task automatic shift_bit(input logic b);
        sck <= 1'b0;
        si <= b;
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : shift_bit

    // one frame: opcode, 24 address bits and data bytes, msb first
    // hbits below 32 cuts the header short on purpose
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nby,
                         input logic [7:0] d0, input int hbits);
        logic [31:0] hdr;
        logic [7:0] d;
        hdr = {op, a};
        // select stays high a few clocks so the sequencer sees the gap
        repeat (4) @(posedge clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < hbits; i++)
            shift_bit(hdr[31 - i]);
        for (int i = 0; i < nby * 8; i++)
        begin
            d = d0 + 8'(i / 8);
            shift_bit(d[7 - i % 8]);
        end
        cs_n <= 1'b1;
        si <= ~si;   // released line must not keep showing the last bit
    endtask : frame
endmodule : sfp_host

`default_nettype wire

// ===== tb/tb_serial_flash_program_erase_cmds.sv
// self-checking bench for the flash program and erase sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_serial_flash_program_erase_cmds;
    import sfp_pkg::*;

    typedef struct {
        logic [7:0] op;
        logic [11:0] pg;
        logic [7:0] mask;
        int cyc;
        logic mism;
        logic sl;
        int nby;
    } sfp_row_s;

    // phase times with the shortened parameters below, 50 cycles per us
    localparam int XC = 2000;
    localparam int PC = 50;
    localparam int BC = 100;
    localparam int GC = 50;
    localparam logic [7:0] MX = 8'h04, ME = 8'h08, MP = 8'h10;

    logic clk, sys_rst, cs_n, sck, si, arr_mismatch, rd_sel, buf_ready;
    logic [7:0] status, rd_data;
    logic [8:0] rd_addr;
    sfp_arr_s arr;
    int errors, check_count;
    logic cmp_last;

    // erase before program-only, far below the per-sector rewrite limit
    sfp_row_s rows [17] = '{
        '{8'h83, 12'hABC, ME | MP, PC + GC, 1'b0, 1'b0, 0},
        '{8'h86, 12'h123, ME | MP, PC + GC, 1'b0, 1'b1, 0},
        '{8'h81, 12'h456, ME, PC, 1'b0, 1'b0, 0},
        '{8'h88, 12'h456, MP, GC, 1'b0, 1'b0, 0},
        '{8'h81, 12'h457, ME, PC, 1'b0, 1'b0, 0},
        '{8'h89, 12'h457, MP, GC, 1'b0, 1'b1, 0},
        '{8'h50, 12'hFFF, ME, BC, 1'b0, 1'b0, 0},
        '{8'h50, 12'h00B, ME, BC, 1'b0, 1'b0, 0},
        '{8'h53, 12'h321, MX, XC, 1'b0, 1'b0, 0},
        '{8'h55, 12'h321, MX, XC, 1'b0, 1'b1, 0},
        '{8'h60, 12'h200, MX, XC, 1'b1, 1'b0, 0},
        '{8'h53, 12'h201, MX, XC, 1'b0, 1'b0, 0},
        '{8'h61, 12'h200, MX, XC, 1'b0, 1'b1, 0},
        '{8'h58, 12'h7FF, MX | ME | MP, XC + PC + GC, 1'b0, 1'b0, 0},
        '{8'h59, 12'h800, MX | ME | MP, XC + PC + GC, 1'b0, 1'b1, 0},
        '{8'h82, 12'h0F0, ME | MP, PC + GC, 1'b0, 1'b0, 3},
        '{8'h85, 12'h0F1, ME | MP, PC + GC, 1'b0, 1'b1, 3}
    };

    sfp_core #(.XFR_US(40), .PAGE_ER_US(1), .BLK_ER_US(2), .PROG_US(1)) uut (
        .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si),
        .status(status), .buf_ready(buf_ready), .arr(arr), .arr_mismatch(arr_mismatch),
        .rd_sel(rd_sel), .rd_addr(rd_addr), .rd_data(rd_data));

    sfp_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));

    // 50 MHz system clock
    always #10 clk = ~clk;

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // a wait that runs out is a mismatch and ends the run
    task automatic wait_rdy(input logic lvl, input int lim);
        int i;
        i = 0;
        @(posedge clk);
        #1;
        while (status[RDY_BIT] !== lvl && i < lim)
        begin
            @(posedge clk);
            #1;
            i++;
        end
        check("ready level", 32'(lvl), 32'(status[RDY_BIT]));
        if (status[RDY_BIT] !== lvl)
            summarize();
    endtask : wait_rdy

    // buffer read port answers one edge after the address is taken
    task automatic rd_chk(input logic s, input logic [8:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_sel <= s;
        rd_addr <= a;
        @(posedge clk);
        #1;
        check("buffer byte", 32'(e), 32'(rd_data));
    endtask : rd_chk

    // one array command: launch, watch phases and page, time the busy span
    task automatic run_op(input sfp_row_s r);
        logic [7:0] seen;
        logic [11:0] pg;
        logic sl;
        logic bk;
        int n;
        seen = '0;
        {pg, sl, bk} = '0;
        n = 0;
        @(posedge clk);
        arr_mismatch <= r.mism;
        host.frame(r.op, {3'h5, r.pg, 9'h155}, r.nby, 8'hC3, 32);
        wait_rdy(1'b0, 20);
        while (status[RDY_BIT] === 1'b0 && n < 5000)
        begin
            if (arr.phase inside {PH_XFER, PH_ERASE, PH_PROG})
            begin
                seen[arr.phase] = 1'b1;
                {pg, sl, bk} = {arr.page, arr.sel, arr.block};
            end
            n++;
            @(posedge clk);
            #1;
        end
        if (r.op inside {8'h60, 8'h61})
            cmp_last = r.mism;
        check("phases run", 32'(r.mask), 32'(seen));
        check("busy span fits", 32'h1, 32'(n >= r.cyc && n <= r.cyc + 8));
        check("page", 32'(r.op == 8'h50 ? {r.pg[11:3], 3'h0} : r.pg), 32'(pg));
        check("buffer select", 32'(r.sl), 32'(sl));
        check("block flag", 32'(r.op == 8'h50), 32'(bk));
        check("compare bit", 32'(cmp_last), 32'(status[CMP_BIT]));
        $display("test op %h done", r.op);
        if (n == 5000)
            summarize();
    endtask : run_op

    //--------------------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------------------
    initial
    begin
        logic refused;
        int busy;
        clk = 1'b0;
        sys_rst = 1'b1;
        arr_mismatch = 1'b0;
        rd_sel = 1'b0;
        rd_addr = '0;
        errors = 0;
        check_count = 0;
        cmp_last = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check("status in reset", 32'hA4, 32'(status));
        check("phase in reset", 32'(PH_IDLE), 32'(arr.phase));
        check("fifo ready in reset", 32'h1, 32'(buf_ready));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        $display("test reset done");
        for (int k = 0; k < 17; k++)
            run_op(rows[k]);
        // buffer writes wrap past the last byte; the second sets ignored bits 22 to 9 to ones
        host.frame(8'h84, 24'h000106, 4, 8'h10, 32);
        host.frame(8'h87, 24'h7FFEFF, 2, 8'h20, 32);
        repeat (16) @(posedge clk);
        #1;
        check("ready after writes", 32'h1, 32'(status[RDY_BIT]));
        for (int i = 0; i < 4; i++)
            rd_chk(1'b0, 9'((262 + i) % 264), 8'h10 + 8'(i));
        rd_chk(1'b1, 9'h0FF, 8'h20);
        rd_chk(1'b1, 9'h100, 8'h21);
        $display("test buffer write done");
        // short header and unknown opcode must launch nothing
        busy = 0;
        host.frame(8'h81, 24'h000000, 0, 8'h00, 31);
        repeat (40)
        begin
            @(posedge clk);
            #1;
            busy += int'(status[RDY_BIT] !== 1'b1);
        end
        host.frame(8'hFF, 24'h000000, 0, 8'h00, 32);
        repeat (40)
        begin
            @(posedge clk);
            #1;
            busy += int'(status[RDY_BIT] !== 1'b1);
        end
        check("busy after discard", 32'h0, 32'(busy));
        $display("test discard done");
        // writes to the buffer being transferred stall until the fifo refuses
        refused = 1'b0;
        host.frame(8'h53, 24'h000000, 0, 8'h00, 32);
        fork
            host.frame(8'h84, 24'h000000, 20, 8'h40, 32);
            for (int i = 0; i < 1700; i++)
            begin
                @(posedge clk);
                #1;
                if (buf_ready === 1'b0)
                    refused = 1'b1;
            end
        join
        check("fifo refused", 32'h1, 32'(refused));
        wait_rdy(1'b1, 3000);
        repeat (20) @(posedge clk);
        #1;
        check("fifo drained", 32'h1, 32'(buf_ready));
        rd_chk(1'b0, 9'h000, 8'h40);
        rd_chk(1'b0, 9'h00F, 8'h4F);
        $display("test fifo fill done");
        // reset in mid-transfer must drop the operation at once
        host.frame(8'h53, 24'h000000, 0, 8'h00, 32);
        wait_rdy(1'b0, 20);
        repeat (50) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("status in mid reset", 32'hA4, 32'(status));
        check("phase in mid reset", 32'(PH_IDLE), 32'(arr.phase));
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("ready after mid reset", 32'h1, 32'(status[RDY_BIT]));
        $display("test mid reset done");
        summarize();
    end
endmodule : tb_serial_flash_program_erase_cmds

`default_nettype wire
